// ### ppc_defs.svh
// register offsets, field positions, reset values and timing counts for the PSE port control
// assumes inclusion by the package and the design modules only
//
// Function
// - fault timer expiry drops gate, records timeout event
// - foldback current limit while switch drop exceeds 10V
// - power-good bit set when output under 2.4V
// - 500k idle load connected whenever the port is unpowered: idle, detect and class
// - configuration loaded from standalone pin at reset
// - live standalone pin level at 11h bit 0
// - maskable shutdown resets masked port like shutdown
// - maskable shutdown ignores low pulses under 1us
// - type-1 grade: no two-event, class 4 as 0
// - power only after 25k signature detected
// - open circuit after power removes port power
// - current fault or short removes port power
// - type-2 grade runs detect, classify, power unaided
// - port shutdown input overrides registers, 1us filter
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH

// register map
`define PPC_ADDR_PIN_STATE   8'h11
`define PPC_ADDR_MISC_CFG    8'h17
`define PPC_ADDR_PORT_STATUS 8'h30
`define PPC_ADDR_PORT_CFG    8'h31

// field positions
`define PPC_PIN_STANDALONE   0
`define PPC_MISC_MASK        0
`define PPC_STAT_OVERCURRENT 0
`define PPC_STAT_INRUSH      1
`define PPC_STAT_PGOOD       2
`define PPC_CFG_AUTO         0
`define PPC_CFG_DETECT       1
`define PPC_CFG_CLASS        2
`define PPC_CFG_POWER_REQ    3
`define PPC_CFG_IMASK_LO     4

// reset values
`define PPC_MISC_CFG_RST     8'h00
`define PPC_CFG_RST_AUTO     8'h77
`define PPC_CFG_RST_HOST     8'h70
`define PPC_STATUS_RST       3'h0

// class codes
`define PPC_CLASS_0          3'h0
`define PPC_CLASS_4          3'h4

// timing: shutdown glitch filter
`define PPC_CLK_MHZ          40
`define PPC_GLITCH_NS        1000
`define PPC_GLITCH_CYC       ((`PPC_GLITCH_NS * `PPC_CLK_MHZ + 999) / 1000)
`define PPC_GLITCH_CW        6

`endif

// ### ppc_filt_if.sv
// carrier between a raw active-low shutdown pin and its glitch filter
// assumes one clock domain, sys_clk
`timescale 1ns/10ps
interface ppc_filt_if;
	logic raw_n;
	logic clean_n;

	modport filt (input raw_n, output clean_n);
	modport user (output raw_n, input clean_n);
endinterface

// ### ppc_glitch_filter.sv
// active-low glitch filter: low must persist for the filter time before it passes
// assumes the raw input is synchronous to sys_clk
`timescale 1ns/10ps
`include "ppc_defs.svh"
module ppc_glitch_filter
	import ppc_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// pin in, filtered level out
	ppc_filt_if.filt  fl
);
	localparam logic [`PPC_GLITCH_CW-1:0] LOW_MAX = `PPC_GLITCH_CW'(`PPC_GLITCH_CYC - 1);

	logic [`PPC_GLITCH_CW-1:0] lo_cnt;
	logic [`PPC_GLITCH_CW-1:0] next_lo_cnt;
	logic                      clean_n;
	logic                      next_clean_n;

	// high releases at once; low asserts only after a full filter time
	always_comb begin
		next_lo_cnt  = lo_cnt;
		next_clean_n = clean_n;
		if (fl.raw_n) begin
			next_lo_cnt  = '0;
			next_clean_n = 1'b1;
		end else if (lo_cnt == LOW_MAX) begin
			next_clean_n = 1'b0;
		end else begin
			next_lo_cnt = lo_cnt + `PPC_GLITCH_CW'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lo_cnt  <= '0;
			clean_n <= 1'b1;
		end else begin
			lo_cnt  <= next_lo_cnt;
			clean_n <= next_clean_n;
		end
	end

	assign fl.clean_n = clean_n;

	a_glitch_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(clean_n) |-> (!$past(fl.raw_n) && $past(lo_cnt) == LOW_MAX))
		else $error("filtered shutdown fell before the filter time");
	a_glitch_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
		fl.raw_n |=> clean_n)
		else $error("filtered shutdown did not release when input went high");
endmodule

// ### ppc_pd_model.sv
// powered device at the far end of the cable, seen as digital levels
// assumes sys_clk domain and the port control outputs as its probes
`timescale 1ns/10ps
module ppc_pd_model
	import ppc_pkg::*;
(
	// clock
	input  wire logic       sys_clk,
	// bench controls
	input  wire logic       present,
	input  wire ppc_class_t cls,
	// probes from the port control
	input  wire logic       detect_en,
	input  wire logic       class_en,
	input  wire logic       gate_on,
	// answers to the port control
	output logic            sig_valid,
	output logic            class_done,
	output ppc_class_t      pd_class,
	output logic            open_circuit,
	output logic            out_below_2v4
);
	logic [2:0] ramp;
	logic [2:0] next_ramp;

	// signature resistance only shows while probed
	assign sig_valid = present & detect_en;
	assign class_done = present & class_en;
	// class lines float to the inverse outside classification
	assign pd_class = class_en ? cls : ~cls;
	// no load current once unplugged
	assign open_circuit = gate_on & ~present;
	assign out_below_2v4 = ramp == 3'h7;

	// output settles a few cycles after the switch closes
	always_comb begin
		next_ramp = gate_on ? ramp + {2'h0, ramp != 3'h7} : 3'h0;
	end
	always_ff @(posedge sys_clk) begin
		ramp <= next_ramp;
	end
endmodule

// ### ppc_pkg.sv
// types shared by the PSE port control modules
// assumes ppc_defs.svh is on the include path
package ppc_pkg;
	`include "ppc_defs.svh"

	// port sequencing states, gray coded along detect-class-inrush-powered
	typedef enum logic [2:0] {
		PPC_IDLE    = 3'h0,
		PPC_DETECT  = 3'h1,
		PPC_CLASS   = 3'h3,
		PPC_INRUSH  = 3'h2,
		PPC_POWERED = 3'h6
	} ppc_state_t;

	typedef logic [7:0] ppc_byte_t;
	typedef logic [2:0] ppc_class_t;
endpackage

// ### ppc_port_power_control.sv
// PSE single-port power control: sequencing, gate drive, fault events, registers
// assumes detection, classification and analog monitors deliver sync digital levels
`timescale 1ns/10ps
`include "ppc_defs.svh"
module ppc_port_power_control
	import ppc_pkg::*;
#(
	parameter bit TYPE1_ONLY = 1'b0
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// control pins
	input  wire logic       standalone_pin,
	input  wire logic       port_shutdown_n,
	input  wire logic       maskable_shutdown_n,
	// analog front-end results
	input  wire logic       sig_valid,
	input  wire logic       class_done,
	input  wire ppc_class_t pd_class,
	input  wire logic       fault_timer_expired,
	input  wire logic       current_fault,
	input  wire logic       short_circuit,
	input  wire logic       open_circuit,
	input  wire logic       vds_above_10v,
	input  wire logic       out_below_2v4,
	// register port
	input  wire ppc_byte_t  reg_addr,
	input  wire ppc_byte_t  reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output ppc_byte_t       reg_rdata,
	// drives to the analog front-end, and the host interrupt
	output logic            gate_on,
	output logic            foldback_en,
	output logic            idle_load_en,
	output logic            detect_en,
	output logic            class_en,
	output logic            two_event_class_en,
	output ppc_class_t      class_eff,
	output logic            int_n
);
	////////////////////////////////////////////////////////////////////////////
	// shutdown filters
	ppc_filt_if flt [2] ();
	logic [1:0] raw_pins;
	assign raw_pins = {maskable_shutdown_n, port_shutdown_n};

	generate
		for (genvar i = 0; i < 2; i++) begin : g_filt
			assign flt[i].raw_n = raw_pins[i];
			ppc_glitch_filter u_filt (
				.sys_clk (sys_clk),
				.sys_rst (sys_rst),
				.fl      (flt[i])
			);
		end
	endgenerate

	logic port_shutdown_n_clean_n;
	logic msd_clean_n;
	assign port_shutdown_n_clean_n = flt[0].clean_n;
	assign msd_clean_n  = flt[1].clean_n;

	function automatic logic addr_is(input ppc_byte_t a, input ppc_byte_t ref_a);
		return a == ref_a;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// registers
	ppc_byte_t  misc_cfg;
	ppc_byte_t  next_misc_cfg;
	ppc_byte_t  port_cfg;
	ppc_byte_t  next_port_cfg;
	logic [2:0] status;
	logic [2:0] next_status;
	logic       cfg_loaded;
	logic       next_cfg_loaded;
	ppc_byte_t  next_reg_rdata;
	logic       next_int_n;
	logic [2:0] ev_set;
	logic       port_reset;

	// port shutdown always resets the port; maskable shutdown only while the mask bit is set
	assign port_reset = !port_shutdown_n_clean_n
		|| (!msd_clean_n && misc_cfg[`PPC_MISC_MASK]);

	always_comb begin
		next_misc_cfg   = misc_cfg;
		next_port_cfg   = port_cfg;
		next_cfg_loaded = 1'b1;
		next_reg_rdata  = reg_rdata;
		next_status     = status;
		// first cycle after reset release catches the strap level
		if (!cfg_loaded) begin
			next_port_cfg = standalone_pin ? `PPC_CFG_RST_AUTO : `PPC_CFG_RST_HOST;
		end else if (reg_wr) begin
			if (addr_is(reg_addr, `PPC_ADDR_MISC_CFG))
				next_misc_cfg = reg_wdata;
			if (addr_is(reg_addr, `PPC_ADDR_PORT_CFG))
				next_port_cfg = reg_wdata;
		end
		if (reg_rd) begin
			if (addr_is(reg_addr, `PPC_ADDR_PIN_STATE))
				next_reg_rdata = {7'h00, standalone_pin};
			else if (addr_is(reg_addr, `PPC_ADDR_MISC_CFG))
				next_reg_rdata = misc_cfg;
			else if (addr_is(reg_addr, `PPC_ADDR_PORT_STATUS))
				next_reg_rdata = {5'h00, status};
			else if (addr_is(reg_addr, `PPC_ADDR_PORT_CFG))
				next_reg_rdata = port_cfg;
			else
				next_reg_rdata = 8'h00;
			// reading status clears it
			if (addr_is(reg_addr, `PPC_ADDR_PORT_STATUS))
				next_status = 3'h0;
		end
		// a new event wins over the read clear
		next_status = next_status | ev_set;
		next_int_n  = !(|(next_status & port_cfg[`PPC_CFG_IMASK_LO +: 3]));
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			misc_cfg   <= `PPC_MISC_CFG_RST;
			port_cfg   <= `PPC_CFG_RST_HOST;
			status     <= `PPC_STATUS_RST;
			cfg_loaded <= 1'b0;
			reg_rdata  <= 8'h00;
			int_n      <= 1'b1;
		end else begin
			misc_cfg   <= next_misc_cfg;
			port_cfg   <= next_port_cfg;
			status     <= next_status;
			cfg_loaded <= next_cfg_loaded;
			reg_rdata  <= next_reg_rdata;
			int_n      <= next_int_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// port sequencer
	ppc_state_t state;
	ppc_state_t next_state;
	logic       sig_ok;
	logic       next_sig_ok;
	ppc_class_t next_class_eff;
	logic       next_two_event;
	logic       power_ok;
	logic       pwr_fault;

	// host or automatic mode may apply power; type-2 grade runs unaided in auto
	assign power_ok  = port_cfg[`PPC_CFG_AUTO] || port_cfg[`PPC_CFG_POWER_REQ];
	assign pwr_fault = current_fault || short_circuit;

	always_comb begin
		next_state     = state;
		next_sig_ok    = sig_ok;
		next_class_eff = class_eff;
		next_two_event = 1'b0;
		ev_set         = 3'h0;
		case (state)
		PPC_IDLE: begin
			next_sig_ok = 1'b0;
			if (port_cfg[`PPC_CFG_DETECT] && cfg_loaded)
				next_state = PPC_DETECT;
		end
		PPC_DETECT: begin
			if (sig_valid) begin
				next_sig_ok = 1'b1;
				next_state  = port_cfg[`PPC_CFG_CLASS] ? PPC_CLASS : PPC_INRUSH;
				if (!port_cfg[`PPC_CFG_CLASS])
					next_class_eff = `PPC_CLASS_0;
				if (!port_cfg[`PPC_CFG_CLASS] && !power_ok)
					next_state = PPC_DETECT;
			end
		end
		PPC_CLASS: begin
			next_two_event = !TYPE1_ONLY && (class_eff == `PPC_CLASS_4);
			if (class_done) begin
				// type-1 grade treats class 4 as class 0
				if (TYPE1_ONLY && pd_class == `PPC_CLASS_4)
					next_class_eff = `PPC_CLASS_0;
				else
					next_class_eff = pd_class;
				if (power_ok && sig_ok)
					next_state = PPC_INRUSH;
				else if (!power_ok)
					next_state = PPC_DETECT;
			end
		end
		PPC_INRUSH: begin
			if (fault_timer_expired) begin
				ev_set[`PPC_STAT_INRUSH] = 1'b1;
				next_state = PPC_IDLE;
			end else if (pwr_fault) begin
				next_state = PPC_IDLE;
			end else if (out_below_2v4) begin
				next_state = PPC_POWERED;
			end
		end
		PPC_POWERED: begin
			if (fault_timer_expired) begin
				ev_set[`PPC_STAT_OVERCURRENT] = 1'b1;
				next_state = PPC_IDLE;
			end else if (pwr_fault || open_circuit) begin
				next_state = PPC_IDLE;
			end
		end
		default: next_state = PPC_IDLE;
		endcase
		if (gate_on && out_below_2v4)
			ev_set[`PPC_STAT_PGOOD] = 1'b1;
		// a live fault forbids power at any stage, not only once powered
		if (port_reset || pwr_fault || !cfg_loaded) begin
			next_state     = PPC_IDLE;
			next_sig_ok    = 1'b0;
			next_two_event = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state              <= PPC_IDLE;
			sig_ok             <= 1'b0;
			class_eff          <= `PPC_CLASS_0;
			two_event_class_en <= 1'b0;
			gate_on            <= 1'b0;
			foldback_en        <= 1'b0;
			idle_load_en       <= 1'b1;
			detect_en          <= 1'b0;
			class_en           <= 1'b0;
		end else begin
			state              <= next_state;
			sig_ok             <= next_sig_ok;
			class_eff          <= next_class_eff;
			two_event_class_en <= next_two_event;
			// gate follows the state; any exit to idle drops it
			gate_on            <= (next_state == PPC_INRUSH) || (next_state == PPC_POWERED);
			foldback_en        <= vds_above_10v;
			idle_load_en       <= !((next_state == PPC_INRUSH) || (next_state == PPC_POWERED));
			detect_en          <= (next_state == PPC_DETECT);
			class_en           <= (next_state == PPC_CLASS);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_timer_gate_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(fault_timer_expired && gate_on) |=> (!gate_on && (status[0] || status[1])))
		else $error("fault timer expiry did not drop gate and record event");
	a_foldback_track: assert property (@(posedge sys_clk) disable iff (sys_rst)
		vds_above_10v |=> foldback_en)
		else $error("foldback not enabled above 10V switch drop");
	a_pgood_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(gate_on && out_below_2v4) |=> status[`PPC_STAT_PGOOD])
		else $error("power-good bit not set");
	a_idle_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		idle_load_en != gate_on)
		else $error("idle load not complementary to port power");
	a_strap_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!cfg_loaded |=> port_cfg[`PPC_CFG_AUTO] == $past(standalone_pin))
		else $error("configuration not loaded from standalone pin");
	a_pin_live: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(reg_rd && reg_addr == `PPC_ADDR_PIN_STATE) |=> reg_rdata == {7'h00, $past(standalone_pin)})
		else $error("pin status bit 0 not the live standalone level");
	a_mask_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!msd_clean_n && misc_cfg[`PPC_MISC_MASK]) |=> (!gate_on && state == PPC_IDLE))
		else $error("masked shutdown did not reset port");
	a_port_shutdown_n_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!port_shutdown_n_clean_n |=> !gate_on)
		else $error("port shutdown did not remove power");
	a_type1_class: assert property (@(posedge sys_clk) disable iff (sys_rst)
		TYPE1_ONLY |-> (class_eff != `PPC_CLASS_4 && !two_event_class_en))
		else $error("type-1 grade used class 4 or two-event class");
	a_sig_first: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(gate_on) |-> $past(sig_ok || sig_valid))
		else $error("power applied without signature");
	a_open_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(open_circuit && state == PPC_POWERED) |=> !gate_on)
		else $error("open circuit did not remove power");
	a_fault_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(current_fault || short_circuit) |=> !gate_on)
		else $error("current fault did not remove power");
	a_event_int: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(|(status & port_cfg[`PPC_CFG_IMASK_LO +: 3])) |-> ##[0:1] !int_n)
		else $error("unmasked status did not raise interrupt");
	a_cfg_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cfg_loaded && reg_wr && reg_addr == `PPC_ADDR_PORT_CFG)
			|=> port_cfg == $past(reg_wdata))
		else $error("configuration not writable after strap load");
	a_status_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!(reg_rd && reg_addr == `PPC_ADDR_PORT_STATUS)
			|=> (status & $past(status)) == $past(status))
		else $error("status bit lost without a read");
	a_inrush_event: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state == PPC_INRUSH && fault_timer_expired) |=> status[`PPC_STAT_INRUSH])
		else $error("inrush timeout not recorded");
	a_cut_event: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state == PPC_POWERED && fault_timer_expired) |=> status[`PPC_STAT_OVERCURRENT])
		else $error("overcurrent timeout not recorded");
	a_auto_power: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state == PPC_CLASS && class_done && sig_ok && port_cfg[`PPC_CFG_AUTO]
			&& !port_reset && !pwr_fault) |=> gate_on)
		else $error("automatic mode did not apply power after classification");
	a_reset_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		port_reset |=> (state == PPC_IDLE && !gate_on))
		else $error("shutdown request did not return port to idle");
endmodule

// ### ppc_port_power_control_tb.sv
// self-checking bench: both grades side by side with a device model
// assumes ppc_pkg, the design modules and ppc_pd_model compile first
`timescale 1ns/10ps
module ppc_port_power_control_tb
	import ppc_pkg::*;
;
	logic sys_clk = 1'b0, sys_rst = 1'b1, standalone_pin = 1'b0, present = 1'b0;
	logic port_shutdown_n = 1'b1, maskable_shutdown_n = 1'b1, vds_above_10v = 1'b0;
	logic fault_timer_expired = 1'b0, current_fault = 1'b0, short_circuit = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, mon = 1'b0, vds_seen = 1'b0, b;
	logic two_seen = 1'b0;
	logic sig_valid, class_done, open_circuit, out_below_2v4, t1_two;
	logic gate_on, foldback_en, idle_load_en, detect_en, class_en, two_event_class_en, int_n;
	ppc_class_t cls = 3'h0;
	ppc_class_t pd_class, class_eff, t1_cls;
	ppc_byte_t  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [31:0] lfsr = 32'hC068BA85;
	int failures = 0, compares = 0;

	ppc_port_power_control #(.TYPE1_ONLY(1'b0)) i_ppc_port_power_control (.*);
	ppc_port_power_control #(.TYPE1_ONLY(1'b1)) i_ppc_port_power_control_t1 (.*,
		.reg_rdata(), .gate_on(), .foldback_en(), .idle_load_en(), .detect_en(),
		.class_en(), .two_event_class_en(t1_two), .class_eff(t1_cls), .int_n());
	ppc_pd_model i_ppc_pd_model (.*);

	always #12.5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic waitfor(int sel, logic lvl, int lim);
		for (int n = 0; (sel == 1 ? int_n : sel == 2 ? out_below_2v4 : gate_on) !== lvl; n++) begin
			if (n > lim) begin
				failures++;
				$display("ERROR wait expected %h seen timeout", lvl);
				stop_test;
			end
			@(posedge sys_clk);
			#1;
		end
	endtask
	task automatic do_reset(logic pin);
		mon = 1'b0;
		@(posedge sys_clk);
		{sys_rst, standalone_pin} <= {1'b1, pin};
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		mon = 1'b1;
	endtask
	task automatic wr(ppc_byte_t a, ppc_byte_t d);
		@(posedge sys_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(ppc_byte_t a, ppc_byte_t exp, string what);
		@(posedge sys_clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, reg_rdata, exp);
	endtask
	task automatic trip;
		@(posedge sys_clk);
		fault_timer_expired <= 1'b1;
		@(posedge sys_clk);
		fault_timer_expired <= 1'b0;
		#1;
		chk("gate_trip", gate_on, 1'b0);
	endtask
	task automatic shut(logic [1:0] pins, int len, logic exp_gate);
		@(posedge sys_clk);
		{port_shutdown_n, maskable_shutdown_n} <= pins;
		for (int i = 1; i <= len; i++) begin
			@(posedge sys_clk);
			if (i == len) {port_shutdown_n, maskable_shutdown_n} <= 2'b11;
			#1;
			if (i == 39) chk("gate_early", gate_on, 1'b1);
		end
		chk("gate_shut", gate_on, exp_gate);
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		lfsr <= nxt(lfsr);
		vds_above_10v <= lfsr[3];
		vds_seen <= vds_above_10v;
		if (mon) two_seen <= two_seen | two_event_class_en;
	end
	always @(negedge sys_clk) begin
		if (mon) begin
			chk("foldback", foldback_en, vds_seen);
			chk("idle_load", idle_load_en, !gate_on);
			chk("two_event_t1", t1_two, 1'b0);
		end
	end

	initial begin
		do_reset(1'b0);
		rd(8'h31, 8'h70, "cfg_host");
		rd(8'h17, 8'h00, "misc_rst");
		wr(8'h11, 8'hFF);
		wr(8'h31, 8'h5A);
		rd(8'h31, 8'h5A, "cfg_wr");
		rd(8'h20, 8'h00, "unmapped");
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			b = lfsr[0];
			standalone_pin <= b;
			rd(8'h11, {7'h00, b}, "pin_live");
		end
		repeat (20) @(posedge sys_clk);
		chk("gate_nosig", gate_on, 1'b0);
		present <= 1'b1;
		do_reset(1'b1);
		rd(8'h31, 8'h77, "cfg_auto");
		waitfor(1, 1'b0, 100);
		trip;
		rd(8'h30, 8'h05, "status_cut");
		waitfor(0, 1'b1, 50);
		trip;
		rd(8'h30, 8'h02, "status_start");
		chk("int_clear", int_n, 1'b1);
		for (int k = 0; k < 5; k++) begin
			waitfor(2, 1'b1, 50);
			@(posedge sys_clk);
			case (k % 3)
				0: present <= 1'b0;
				1: current_fault <= 1'b1;
				default: short_circuit <= 1'b1;
			endcase
			@(posedge sys_clk);
			{present, current_fault, short_circuit, cls} <= {3'b100, k[2:0]};
			#1;
			chk("gate_kill", gate_on, 1'b0);
			waitfor(0, 1'b1, 50);
			chk("class_eff", class_eff, k[2:0]);
			chk("class_t1", t1_cls, k == 4 ? 3'h0 : k[2:0]);
		end
		shut(2'b10, 45, 1'b1);
		wr(8'h17, 8'h01);
		shut(2'b10, 39, 1'b1);
		shut(2'b10, 45, 1'b0);
		waitfor(0, 1'b1, 100);
		shut(2'b01, 39, 1'b1);
		shut(2'b01, 45, 1'b0);
		chk("two_event", two_seen, 1'b1);
		stop_test;
	end
endmodule
